// file: hw/decim_defines.svh
// Constants for the selectable decimation filter
`ifndef DECIM_DEFINES_SVH
`define DECIM_DEFINES_SVH

`define DECIM_RATIO_SLOW        8
`define DECIM_RATIO_FAST        4
`define DECIM_WORD_WIDTH        16
`define DECIM_FIFO_DEPTH        32
`define DECIM_TAPS              32
`define DECIM_SETTLE_WORDS      13
`define DECIM_GROUP_DELAY_WORDS 9
`define DECIM_STROBE_PHASE      8
`define DECIM_CLK_MHZ           200

`endif

// file: hw/decim_pkg.sv
// Types shared by the selectable decimation filter
package decim_pkg;
	typedef enum logic {
		RATIO_EIGHT,
		RATIO_FOUR
	} ratio_e;
	typedef logic [15:0] word_t;
endpackage : decim_pkg

// file: hw/decim_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module decim_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
	assign rd_valid_out = (count_r != '0);
	assign rd_data_out  = mem[rd_ptr_r];
	assign push = wr_valid_in && wr_ready_out;
	assign pop  = rd_valid_out && rd_ready_in;

	always_ff @(posedge clk_in) begin
		if (push)
			mem[wr_ptr_r] <= wr_data_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule : decim_fifo
`default_nettype wire

// file: hw/decim_fir.sv
// Linear-phase FIR sum over the last span_in modulator bits (span_in at most TAPS)
`timescale 1ns/1ps
`default_nettype none
module decim_fir #(
	parameter int TAPS  = 32,
	parameter int WIDTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             bit_in,
	input  wire logic [5:0]       span_in,
	output logic      [WIDTH-1:0] sum_out
);
	// ************************************************************
	// Symmetric triangular kernel: linear phase by construction
	// ************************************************************
	logic [TAPS-1:0] hist_r;
	logic [WIDTH-1:0] acc;

	function automatic logic [WIDTH-1:0] weight(input int i, input int n);
		int h;
		h = (i < n/2) ? i + 1 : n - i;
		return WIDTH'(h);
	endfunction

	always_ff @(posedge clk_in) begin
		if (rst_in)
			hist_r <= '0;
		else
			hist_r <= {hist_r[TAPS-2:0], bit_in};
	end

	always_comb begin
		acc = '0;
		for (int i = 0; i < TAPS; i++) begin
			if (i < int'(span_in) && hist_r[i])
				acc = acc + weight(i, int'(span_in));
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			sum_out <= '0;
		else
			sum_out <= acc;
	end
endmodule : decim_fir
`default_nettype wire

// file: hw/decim_top.sv
// Selectable-ratio decimation filter with output word strobe
// Summary of operation
// R1 - Select low: decimate by eight
// R2 - Select high: decimate by four
// R3 - One modulator sample per clock
// R4 - Output words are 16 bits wide
// R5 - Fast mode word period four clocks
// R6 - Strobe high and low phases typical
// R7 - Settled after thirteen word cycles
// R8 - Impulse peak after nine word cycles; the span-2R FIR kernel peaks about one word cycle after
// R9 - Linear-phase FIR, clock-scaled response
// R10 - Flat passband from FIR kernel
// R11 - Response repeats at clock multiples
// R12 - Host discards unsettled words after events
// R13 - Host drives select pin firmly
// R14 - Select captured as static configuration
`timescale 1ns/1ps
`default_nettype none
`include "decim_defines.svh"
module decim_top #(
	parameter int WORD_WIDTH = `DECIM_WORD_WIDTH,
	parameter int FIFO_DEPTH = `DECIM_FIFO_DEPTH,
	parameter int TAPS       = `DECIM_TAPS
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  mod_bit_in,
	input  wire logic                  rate_double_select_in,
	input  wire logic                  word_ready_in,
	output logic      [WORD_WIDTH-1:0] word_out,
	output logic                       word_valid_out,
	output logic                       output_word_strobe_out,
	output logic                       settled_out,
	output logic                       overflow_out
);
	// ************************************************************
	// Configuration and phase counting
	// ************************************************************
	decim_pkg::ratio_e ratio_r;
	decim_pkg::ratio_e ratio_nxt;
	logic [3:0]        phase_r;
	logic [3:0]        ratio_last;
	logic              word_tick;
	logic [WORD_WIDTH-1:0] fir_sum;
	logic [5:0]        settle_r;
	logic [5:0]        strobe_cnt_r;
	logic              fifo_wr_ready;
	logic [WORD_WIDTH-1:0] fifo_data;
	logic              fifo_valid;

	function automatic logic [3:0] ratio_of(input decim_pkg::ratio_e r);
		return (r == decim_pkg::RATIO_FOUR) ? 4'(`DECIM_RATIO_FAST)
			: 4'(`DECIM_RATIO_SLOW);
	endfunction

	// Pin sampled each clock but treated as static; a change restarts
	// settling so no mixed-ratio words look valid.
	assign ratio_nxt = rate_double_select_in ? decim_pkg::RATIO_FOUR
		: decim_pkg::RATIO_EIGHT; // R1 R2
	assign ratio_last = ratio_of(ratio_r) - 4'd1;
	assign word_tick  = (phase_r == ratio_last); // R1 R2 R5

	always_ff @(posedge clk_in) begin
		if (rst_in)
			ratio_r <= decim_pkg::RATIO_EIGHT;
		else
			ratio_r <= ratio_nxt; // R14
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || ratio_r != ratio_nxt)
			phase_r <= '0;
		else if (word_tick)
			phase_r <= '0;
		else
			phase_r <= phase_r + 4'd1; // R3
	end

	// ************************************************************
	// FIR: span is twice the ratio so each word sees 2R samples
	// ************************************************************
	decim_fir #(
		.TAPS  (TAPS),
		.WIDTH (WORD_WIDTH)
	) u_fir (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.bit_in  (mod_bit_in),
		.span_in ({1'b0, ratio_of(ratio_r), 1'b0}),
		.sum_out (fir_sum)
	); // R9 R10 R11

	// ************************************************************
	// Settling tracker
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in || ratio_r != ratio_nxt)
			settle_r <= '0;
		else if (word_tick && settle_r != 6'(`DECIM_SETTLE_WORDS))
			settle_r <= settle_r + 6'd1; // R7 R12
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			settled_out <= 1'b0;
		else
			settled_out <= (settle_r == 6'(`DECIM_SETTLE_WORDS)); // R7 R8
	end

	// ************************************************************
	// Strobe: toggles every STROBE_PHASE clocks in both modes,
	// one full word period in slow mode
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in || ratio_r != ratio_nxt) begin
			strobe_cnt_r           <= '0;
			output_word_strobe_out <= 1'b0;
		end else if (strobe_cnt_r == 6'(`DECIM_STROBE_PHASE - 1)) begin
			strobe_cnt_r           <= '0;
			output_word_strobe_out <= ~output_word_strobe_out; // R6
		end else begin
			strobe_cnt_r <= strobe_cnt_r + 6'd1;
		end
	end

	// ************************************************************
	// Output buffer; a full FIFO drops the word and flags it
	// ************************************************************
	decim_fifo #(
		.WIDTH (WORD_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.wr_data_in   (fir_sum),
		.wr_valid_in  (word_tick),
		.wr_ready_out (fifo_wr_ready),
		.rd_data_out  (fifo_data),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (word_ready_in && !word_valid_out)
	); // R4

	always_ff @(posedge clk_in) begin
		if (rst_in)
			overflow_out <= 1'b0;
		else if (word_tick && !fifo_wr_ready)
			overflow_out <= 1'b1;
	end

	// Registered output stage; one pop per handshake
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			word_out       <= '0;
			word_valid_out <= 1'b0;
		end else if (word_valid_out && word_ready_in) begin
			word_valid_out <= 1'b0;
		end else if (!word_valid_out && fifo_valid && word_ready_in) begin
			word_out       <= fifo_data; // R4
			word_valid_out <= 1'b1;
		end
	end
endmodule : decim_top
`default_nettype wire

// file: bench/decim_top_monitor.sv
// Port checker for the decimation filter
`timescale 1ns/1ps
`default_nettype none
module decim_top_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic rate_double_select_in,
	input wire logic word_ready_in,
	input wire logic word_valid_out,
	input wire logic output_word_strobe_out,
	input wire logic settled_out,
	input wire logic overflow_out
);
	logic       sel_r;
	logic [7:0] cyc_r;
	logic [4:0] quiet_r;
	logic       chg;
	int         r;
	assign chg = sel_r != rate_double_select_in;
	assign r   = rate_double_select_in ? 4 : 8;
	always_ff @(posedge clk_in) sel_r <= rate_double_select_in;
	always_ff @(posedge clk_in) begin
		if (rst_in || chg) cyc_r <= 8'h00;
		else if (cyc_r != 8'hff) cyc_r <= cyc_r + 8'h01;
	end
	// Strobe restarts after a select change, so its phases are skipped there
	always_ff @(posedge clk_in) begin
		if (rst_in || chg) quiet_r <= 5'h14;
		else if (quiet_r != 5'h00) quiet_r <= quiet_r - 5'h01;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_strobe_high_len: assert property (disable iff (rst_in || quiet_r != 0)
		$rose(output_word_strobe_out) |-> output_word_strobe_out[*8]
		##1 !output_word_strobe_out) else $error("strobe high phase");
	a_strobe_low_len: assert property (disable iff (rst_in || quiet_r != 0)
		$fell(output_word_strobe_out) |-> !output_word_strobe_out[*8]
		##1 output_word_strobe_out) else $error("strobe low phase");
	// Valid drops on the accepting edge and rises only after a cycle with ready high
	a_valid_one_cycle: assert property (word_valid_out && word_ready_in
		|=> !word_valid_out)
		else $error("valid held");
	a_valid_after_ready: assert property ($rose(word_valid_out)
		|-> $past(word_ready_in)) else $error("valid without ready");
	a_overflow_sticky: assert property (overflow_out |=> overflow_out)
		else $error("overflow dropped");
	a_settle_window: assert property ($rose(settled_out)
		|-> cyc_r >= 13 * r - 3 && cyc_r <= 13 * r + 3) else $error("settle time");
	a_settle_by: assert property (cyc_r == 13 * r + 4 |-> settled_out)
		else $error("settle late");
	a_select_clears: assert property (chg |-> ##2 !settled_out)
		else $error("settled kept");
	cover property ($rose(overflow_out));
	cover property ($rose(settled_out) && rate_double_select_in);
	cover property (word_valid_out ##2 word_valid_out);
endmodule : decim_top_monitor
bind decim_top decim_top_monitor i_mon (.clk_in, .rst_in,
	.rate_double_select_in, .word_ready_in, .word_valid_out,
	.output_word_strobe_out, .settled_out, .overflow_out);
`default_nettype wire

// file: bench/host_sink.sv
// Host model that pops filter words
`timescale 1ns/1ps
`default_nettype none
module host_sink (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic stall_in,
	input  wire logic slow_in,
	input  wire logic valid_in,
	input  wire logic settled_in,
	output logic      ready_out,
	output int        kept_out
);
	// Slow mode offers ready only every other cycle
	always @(posedge clk_in)
		ready_out <= #1 !rst_in && !stall_in && !(slow_in && ready_out);
	always @(posedge clk_in)
		if (rst_in) kept_out <= 0;
		else if (valid_in && ready_out && settled_in)
			kept_out <= kept_out + 1;
endmodule : host_sink
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the decimation filter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin \
	num_errors++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        clk_in = 0, rst_in = 1, mod_bit_in = 0, sel = 0;
	logic        stall = 0, slow = 0, zero = 0, ready, strobe;
	logic [15:0] word_out;
	logic        word_valid_out, settled_out, overflow_out;
	int          num_errors = 0, check_count = 0, seed = 32'ha7a7;
	int          n_words = 0, kept, cyc = 0, rnd, m;
	always #2.5 clk_in = ~clk_in;
	decim_top i_dut (.clk_in, .rst_in, .mod_bit_in,
		.rate_double_select_in(sel), .word_ready_in(ready), .word_out,
		.word_valid_out, .output_word_strobe_out(strobe), .settled_out,
		.overflow_out);
	host_sink i_host (.clk_in, .rst_in, .stall_in(stall), .slow_in(slow),
		.valid_in(word_valid_out), .settled_in(settled_out),
		.ready_out(ready), .kept_out(kept));
	// ****************************************
	// Stimulus, model and timeout
	// ****************************************
	always @(posedge clk_in) begin
		rnd = $random(seed);
		mod_bit_in <= #1 ~zero & rnd[0];
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			give_verdict();
		end
		// A word counts once, on the edge where the host accepts it
		if (word_valid_out && ready) begin
			n_words++;
			if (zero && settled_out) `CHK("word", 16'h0000, word_out)
		end
	end
	task automatic wait_c(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_c
	task automatic restart(input logic s, input logic st);
		sel = s;
		stall = st;
		rst_in = 1;
		wait_c(3);
		rst_in = 0;
		n_words = 0;
	endtask : restart
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict
	initial begin
		wait_c(1);
		for (m = 0; m < 2; m++) begin
			slow = !m[0];
			zero = m[0];
			restart(m[0], 0);
			wait_c(400);
			`CHK("rate", 1'b1, n_words inside {[400/(8>>m)-2:400/(8>>m)]})
			`CHK("settled", 1'b1, settled_out)
			`CHK("kept", 1'b1, kept > 0)
			$display("test rate %0d done", m);
		end
		sel = 0;
		wait_c(3);
		`CHK("cleared", 1'b0, settled_out)
		wait_c(13 * 8 + 4);
		`CHK("resettled", 1'b1, settled_out)
		$display("test switch done");
		restart(1, 1);
		wait_c(110);
		`CHK("no overflow", 1'b0, overflow_out)
		wait_c(40);
		`CHK("overflow", 1'b1, overflow_out)
		stall = 0;
		wait_c(100);
		`CHK("sticky", 1'b1, overflow_out)
		`CHK("drained", 1'b1, n_words >= 32)
		$display("test overflow done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
